// [rtl/tcar_pkg.sv]
// Package holding offsets, field positions, encodings and constants of the action and range block.
package tcar_pkg;

    // Egress action word field positions.
    localparam int ACT_WIDTH       = 92;
    localparam int ACT_PRIO_POS    = 45;
    localparam int ACT_DEI_POS     = 48;
    localparam int ACT_ENCAP_POS   = 49;
    localparam int ACT_PUSHLEN_POS = 59;
    localparam int ACT_POP_POS     = 62;
    localparam int ACT_SVC_POS     = 65;
    localparam int ACT_OAMVLD_POS  = 75;
    localparam int ACT_OAMIDX_POS  = 76;
    localparam int ACT_PMODE_POS   = 82;
    localparam int ACT_PGRP_POS    = 84;
    localparam int ACT_HIT_POS     = 91;

    // Highest valid indexes and the group count.
    localparam logic [9:0] SVC_MAX    = 10'h0ff;
    localparam logic [6:0] PGRP_MAX   = 7'h16;
    localparam int         PGRP_COUNT = 23;

    // Push length encoding.
    localparam logic [2:0] PUSH_LEN_MIN   = 3'h2;
    localparam logic [5:0] PUSH_BYTES_MIN = 6'h0e;

    // Protection modes.
    localparam logic [1:0] PMODE_NONE    = 2'h0;
    localparam logic [1:0] PMODE_WORKING = 2'h1;
    localparam logic [1:0] PMODE_PROTECT = 2'h2;

    // Range checker types.
    localparam int         RNG_COUNT = 8;
    localparam logic [2:0] RNG_DPORT = 3'h0;
    localparam logic [2:0] RNG_SPORT = 3'h1;
    localparam logic [2:0] RNG_BOTH  = 3'h2;
    localparam logic [2:0] RNG_VID   = 3'h3;
    localparam logic [2:0] RNG_DSCP  = 3'h4;

    // Lookup numbering.
    localparam int         LOOKUP_COUNT  = 4;
    localparam logic [1:0] LK_FIRST_ING  = 2'h0;
    localparam logic [1:0] LK_SECOND_ING = 2'h1;
    localparam logic [1:0] LK_THIRD_ING  = 2'h2;
    localparam logic [1:0] LK_EGRESS     = 2'h3;

    // Register map, byte addresses.
    localparam int          ADDR_W          = 13;
    localparam logic [12:0] REG_RANGE_TYPE  = 13'h0000;
    localparam logic [12:0] REG_RANGE_BOUND = 13'h0020;
    localparam logic [12:0] LOOKUP_STRIDE   = 13'h0400;
    localparam logic [9:0]  OFS_ENTRY       = 10'h000;
    localparam logic [9:0]  OFS_MASK        = 10'h080;
    localparam logic [9:0]  OFS_ACTION      = 10'h100;
    localparam logic [9:0]  OFS_COUNTER     = 10'h180;
    localparam logic [9:0]  OFS_TYPEGRP     = 10'h200;
    localparam logic [9:0]  OFS_STICKY      = 10'h204;
    localparam logic [9:0]  OFS_UPDCTRL     = 10'h208;
    localparam logic [9:0]  OFS_MOVECFG     = 10'h20c;
    localparam logic [9:0]  OFS_CONST       = 10'h210;
    localparam int          CACHE_REPL      = 32;
    localparam int          CONST_COUNT     = 7;

    // Per lookup constants: entry width, entries, subwords, type-group width,
    // default actions, action width, counter width.
    localparam logic [31:0] LK_CONST [LOOKUP_COUNT][CONST_COUNT] = '{
        '{32'h0000009c, 32'h000000c0, 32'h00000002, 32'h00000002,
          32'h00000002, 32'h000000b3, 32'h00000001},
        '{32'h00000180, 32'h00000100, 32'h00000004, 32'h00000002,
          32'h00000001, 32'h00000140, 32'h00000001},
        '{32'h00000180, 32'h00000100, 32'h00000004, 32'h00000003,
          32'h0000000d, 32'h00000067, 32'h00000020},
        '{32'h0000001d, 32'h00000400, 32'h00000001, 32'h00000001,
          32'h0000000b, 32'h0000005b, 32'h00000001}};

    localparam logic [31:0] RESET_WORD = 32'h00000000;

endpackage

// [rtl/tcar_top.sv]
// Egress action decode, layer-4 range key generation and per lookup cache registers.
//
// Operation
// - Decode tag-B priority and drop-eligible values.
// - Encapsulation index selects entry; zero disables push.
// - Push length encodes 0, n/a, 14 to 34 bytes.
// - Nonzero pop field overrides header pop count.
// - Egress service index valid only up to 255.
// - OAM endpoint index applies only when flagged valid.
// - Protection mode discards on working or protected path.
// - Protection group index valid only 0 to 22.
// - Set hit sticky bit on TCAM match.
// - Generate eight-bit range key per frame.
// - Checker uses destination, source or either port.
// - VLAN range input depends on lookup stage.
// - DSCP range input depends on lookup stage.
// - Third lookup keys only TCP/UDP frames.
// - Bounds and types live in configuration registers.
// - Entries reached through replicated cache registers.
// - Each lookup has its own register copy.
//
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps

module tcar_top (
    input  wire logic        clk_i,                 // System clock, 100 MHz.
    input  wire logic        reset_n_i,             // Asynchronous reset, active low.
    input  wire logic        psel_i,                // APB select.
    input  wire logic        penable_i,             // APB enable.
    input  wire logic        pwrite_i,              // APB direction, high for write.
    input  wire logic [12:0] paddr_i,               // APB byte address.
    input  wire logic [31:0] pwdata_i,              // APB write data.
    output logic             pready_o,              // APB ready.
    output logic      [31:0] prdata_o,              // APB read data.
    output logic             pslverr_o,             // APB error for unmapped address.
    input  wire logic        action_valid_i,        // Egress action word present.
    input  wire logic [91:0] action_i,              // Egress action word.
    input  wire logic        tcam_match_i,          // Frame matched this entry.
    input  wire logic [2:0]  header_label_pop_count_i, // Pop count from frame header.
    input  wire logic [22:0] path_protected_i,      // Group uses protected path.
    output logic             decode_valid_o,        // Decoded fields valid.
    output logic      [2:0]  tag_b_priority_value_o,    // Tag-B priority value.
    output logic             tag_b_drop_eligible_value_o, // Tag-B drop-eligible value.
    output logic             encap_push_o,          // Encapsulation push enabled.
    output logic      [9:0]  encapsulation_index_o, // Encapsulation table index.
    output logic      [5:0]  encap_push_bytes_o,    // Bytes pushed.
    output logic      [2:0]  label_pop_count_o,     // Effective pop count.
    output logic             egress_service_valid_o, // Service index in range.
    output logic      [9:0]  egress_service_index_o, // Egress service index.
    output logic             oam_endpoint_apply_o,  // OAM endpoint index in use.
    output logic      [5:0]  oam_endpoint_index_o,  // OAM endpoint index.
    output logic             protection_group_valid_o, // Group index in range.
    output logic      [6:0]  protection_group_index_o, // Protection group index.
    output logic             protection_discard_o,  // Frame is discarded.
    output logic      [91:0] action_update_o,       // Action word, hit bit set on TCAM match.
    output logic             hit_set_o,             // Pulse: hit sticky set.
    input  wire logic        frame_valid_i,         // Frame data present.
    input  wire logic        lookup_third_i,        // High: third lookup, low: second.
    input  wire logic        frame_tcp_udp_i,       // Frame is TCP or UDP.
    input  wire logic [15:0] src_port_i,            // TCP/UDP source port.
    input  wire logic [15:0] dst_port_i,            // TCP/UDP destination port.
    input  wire logic        frame_tagged_i,        // Frame carries a VLAN tag.
    input  wire logic [11:0] frame_vid_i,           // VLAN ID from tag.
    input  wire logic [11:0] port_vid_i,            // Port VLAN ID.
    input  wire logic [11:0] classified_vid_i,      // Classified VLAN ID.
    input  wire logic [5:0]  translated_dscp_i,     // DSCP after basic classification.
    input  wire logic [5:0]  classified_dscp_i,     // Classified DSCP.
    output logic             range_key_valid_o,     // Range key valid.
    output logic      [7:0]  range_key_o            // Range key.
);

    // Configuration state.
    logic [2:0]  range_type_ff [tcar_pkg::RNG_COUNT];
    logic [31:0] range_bound_ff [tcar_pkg::RNG_COUNT];
    // Cache memory: four blocks of 32 words per lookup.
    logic [31:0] cache_mem [tcar_pkg::LOOKUP_COUNT][4*tcar_pkg::CACHE_REPL];
    logic [31:0] typegrp_ff [tcar_pkg::LOOKUP_COUNT];
    logic [31:0] sticky_ff  [tcar_pkg::LOOKUP_COUNT];
    logic [31:0] updctrl_ff [tcar_pkg::LOOKUP_COUNT];
    logic [31:0] movecfg_ff [tcar_pkg::LOOKUP_COUNT];

    // Bus decode.
    logic        wr_en;
    logic        rd_en;
    logic [31:0] rd_word;
    logic        rd_hit;
    logic [1:0]  lk_sel;
    logic [9:0]  lk_ofs;
    logic        lk_area;

    // The access phase is held one wait cycle so read data leaves a flip-flop.
    assign rd_en  = psel_i & penable_i & ~pready_o;
    assign wr_en  = psel_i & penable_i & pready_o & pwrite_i;
    assign lk_area = (paddr_i >= tcar_pkg::LOOKUP_STRIDE) &&
                     (paddr_i < 13'(5 * tcar_pkg::LOOKUP_STRIDE));
    assign lk_sel = 2'(paddr_i[11:10] - 2'h1);
    assign lk_ofs = paddr_i[9:0];

    always_comb begin
        rd_word = tcar_pkg::RESET_WORD;
        rd_hit  = 1'b0;
        if (paddr_i[1:0] != 2'h0) begin
            rd_hit = 1'b0;
        end else if (paddr_i == tcar_pkg::REG_RANGE_TYPE) begin
            rd_hit = 1'b1;
            for (int k = 0; k < tcar_pkg::RNG_COUNT; k++) begin
                rd_word[3*k +: 3] = range_type_ff[k];
            end
        end else if (paddr_i >= tcar_pkg::REG_RANGE_BOUND &&
                     paddr_i < 13'(tcar_pkg::REG_RANGE_BOUND + 13'h0020)) begin
            rd_hit  = 1'b1;
            rd_word = range_bound_ff[paddr_i[4:2]];
        end else if (lk_area) begin
            if (lk_ofs < tcar_pkg::OFS_TYPEGRP) begin
                rd_hit  = 1'b1;
                rd_word = cache_mem[lk_sel][lk_ofs[8:2]];
            end else if (lk_ofs == tcar_pkg::OFS_TYPEGRP) begin
                rd_hit  = 1'b1;
                rd_word = typegrp_ff[lk_sel];
            end else if (lk_ofs == tcar_pkg::OFS_STICKY) begin
                rd_hit  = 1'b1;
                rd_word = sticky_ff[lk_sel];
            end else if (lk_ofs == tcar_pkg::OFS_UPDCTRL) begin
                rd_hit  = 1'b1;
                rd_word = updctrl_ff[lk_sel];
            end else if (lk_ofs == tcar_pkg::OFS_MOVECFG) begin
                rd_hit  = 1'b1;
                rd_word = movecfg_ff[lk_sel];
            end else if (lk_ofs >= tcar_pkg::OFS_CONST &&
                         lk_ofs < 10'(tcar_pkg::OFS_CONST + 10'h01c)) begin
                rd_hit  = 1'b1;
                rd_word = tcar_pkg::LK_CONST[lk_sel][3'(lk_ofs[4:2] - 3'h4)];
            end
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pready_o  <= 1'b0;
            prdata_o  <= tcar_pkg::RESET_WORD;
            pslverr_o <= 1'b0;
        end else begin
            pready_o  <= rd_en;
            if (rd_en) begin
                prdata_o  <= pwrite_i ? tcar_pkg::RESET_WORD : rd_word;
                pslverr_o <= ~rd_hit;
            end else begin
                pslverr_o <= 1'b0;
            end
        end
    end

    // Range configuration registers.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            for (int k = 0; k < tcar_pkg::RNG_COUNT; k++) begin
                range_type_ff[k]  <= tcar_pkg::RNG_DPORT;
                range_bound_ff[k] <= tcar_pkg::RESET_WORD;
            end
        end else if (wr_en && rd_hit) begin
            if (paddr_i == tcar_pkg::REG_RANGE_TYPE) begin
                for (int k = 0; k < tcar_pkg::RNG_COUNT; k++) begin
                    range_type_ff[k] <= pwdata_i[3*k +: 3];
                end
            end else if (paddr_i[12:5] == tcar_pkg::REG_RANGE_BOUND[12:5]) begin
                range_bound_ff[paddr_i[4:2]] <= pwdata_i;
            end
        end
    end

    // Cache words carry no reset; software loads an entry before copying it.
    always_ff @(posedge clk_i) begin
        if (wr_en && rd_hit && lk_area && lk_ofs < tcar_pkg::OFS_TYPEGRP) begin
            cache_mem[lk_sel][lk_ofs[8:2]] <= pwdata_i;
        end
    end

    // Per lookup control registers; each lookup keeps a private copy.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            for (int l = 0; l < tcar_pkg::LOOKUP_COUNT; l++) begin
                typegrp_ff[l] <= tcar_pkg::RESET_WORD;
                updctrl_ff[l] <= tcar_pkg::RESET_WORD;
                movecfg_ff[l] <= tcar_pkg::RESET_WORD;
            end
        end else if (wr_en && lk_area) begin
            unique case (lk_ofs)
                tcar_pkg::OFS_TYPEGRP: typegrp_ff[lk_sel] <= pwdata_i;
                tcar_pkg::OFS_UPDCTRL: updctrl_ff[lk_sel] <= pwdata_i;
                tcar_pkg::OFS_MOVECFG: movecfg_ff[lk_sel] <= pwdata_i;
                default: ;
            endcase
        end
    end

    // Sticky indications clear on a write of one; a hit in the same cycle wins.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            for (int l = 0; l < tcar_pkg::LOOKUP_COUNT; l++) begin
                sticky_ff[l] <= tcar_pkg::RESET_WORD;
            end
        end else begin
            for (int l = 0; l < tcar_pkg::LOOKUP_COUNT; l++) begin
                if (wr_en && lk_area && lk_sel == 2'(l) && lk_ofs == tcar_pkg::OFS_STICKY) begin
                    sticky_ff[l] <= sticky_ff[l] & ~pwdata_i;
                end
            end
            if (action_valid_i && tcam_match_i) begin
                sticky_ff[tcar_pkg::LK_EGRESS][0] <= 1'b1;
            end
        end
    end

    // Action word field extraction.
    logic [2:0] f_prio;
    logic       f_dei;
    logic [9:0] f_encap;
    logic [2:0] f_pushlen;
    logic [2:0] f_pop;
    logic [9:0] f_svc;
    logic       f_oamvld;
    logic [5:0] f_oamidx;
    logic [1:0] f_pmode;
    logic [6:0] f_pgrp;
    logic       pgrp_ok;
    logic       grp_protected;
    logic       nxt_discard;

    assign f_prio    = action_i[tcar_pkg::ACT_PRIO_POS +: 3];
    assign f_dei     = action_i[tcar_pkg::ACT_DEI_POS];
    assign f_encap   = action_i[tcar_pkg::ACT_ENCAP_POS +: 10];
    assign f_pushlen = action_i[tcar_pkg::ACT_PUSHLEN_POS +: 3];
    assign f_pop     = action_i[tcar_pkg::ACT_POP_POS +: 3];
    assign f_svc     = action_i[tcar_pkg::ACT_SVC_POS +: 10];
    assign f_oamvld  = action_i[tcar_pkg::ACT_OAMVLD_POS];
    assign f_oamidx  = action_i[tcar_pkg::ACT_OAMIDX_POS +: 6];
    assign f_pmode   = action_i[tcar_pkg::ACT_PMODE_POS +: 2];
    assign f_pgrp    = action_i[tcar_pkg::ACT_PGRP_POS +: 7];
    assign pgrp_ok   = f_pgrp <= tcar_pkg::PGRP_MAX;
    assign grp_protected = pgrp_ok ? path_protected_i[f_pgrp[4:0]] : 1'b0;

    // An out-of-range group or the reserved mode never discards.
    always_comb begin
        nxt_discard = 1'b0;
        if (pgrp_ok) begin
            if (f_pmode == tcar_pkg::PMODE_WORKING) begin
                nxt_discard = grp_protected;
            end else if (f_pmode == tcar_pkg::PMODE_PROTECT) begin
                nxt_discard = ~grp_protected;
            end
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            decode_valid_o              <= 1'b0;
            tag_b_priority_value_o      <= 3'h0;
            tag_b_drop_eligible_value_o <= 1'b0;
            encap_push_o                <= 1'b0;
            encapsulation_index_o       <= 10'h000;
            encap_push_bytes_o          <= 6'h00;
            label_pop_count_o           <= 3'h0;
            egress_service_valid_o      <= 1'b0;
            egress_service_index_o      <= 10'h000;
            oam_endpoint_apply_o        <= 1'b0;
            oam_endpoint_index_o        <= 6'h00;
            protection_group_valid_o    <= 1'b0;
            protection_group_index_o    <= 7'h00;
            protection_discard_o        <= 1'b0;
            action_update_o             <= '0;
            hit_set_o                   <= 1'b0;
        end else begin
            decode_valid_o <= action_valid_i;
            hit_set_o      <= action_valid_i & tcam_match_i;
            if (action_valid_i) begin
                tag_b_priority_value_o      <= f_prio;
                tag_b_drop_eligible_value_o <= f_dei;
                encapsulation_index_o       <= f_encap;
                // A zero index or a length below two pushes nothing.
                encap_push_o <= (f_encap != 10'h000) &&
                                (f_pushlen >= tcar_pkg::PUSH_LEN_MIN);
                encap_push_bytes_o <= (f_encap != 10'h000 && f_pushlen >= tcar_pkg::PUSH_LEN_MIN) ?
                    6'(tcar_pkg::PUSH_BYTES_MIN +
                       6'({f_pushlen - tcar_pkg::PUSH_LEN_MIN, 2'b00})) : 6'h00;
                label_pop_count_o <= (f_pop != 3'h0) ? f_pop : header_label_pop_count_i;
                egress_service_valid_o   <= f_svc <= tcar_pkg::SVC_MAX;
                egress_service_index_o   <= f_svc;
                oam_endpoint_apply_o     <= f_oamvld;
                oam_endpoint_index_o     <= f_oamvld ? f_oamidx : 6'h00;
                protection_group_valid_o <= pgrp_ok;
                protection_group_index_o <= f_pgrp;
                protection_discard_o     <= nxt_discard;
                action_update_o          <= action_i;
                if (tcam_match_i) begin
                    action_update_o[tcar_pkg::ACT_HIT_POS] <= 1'b1;
                end
            end
        end
    end

    // Range checker inputs, chosen by lookup stage.
    logic [11:0] vid_sel;
    logic [5:0]  dscp_sel;
    logic [7:0]  nxt_range_key;

    assign vid_sel  = lookup_third_i ? classified_vid_i :
                      (frame_tagged_i ? frame_vid_i : port_vid_i);
    assign dscp_sel = lookup_third_i ? classified_dscp_i : translated_dscp_i;

    for (genvar g = 0; g < tcar_pkg::RNG_COUNT; g++) begin : g_rng
        logic [15:0] lo;
        logic [15:0] hi;
        logic        in_dst;
        logic        in_src;
        logic        in_vid;
        logic        in_dscp;
        assign lo      = range_bound_ff[g][15:0];
        assign hi      = range_bound_ff[g][31:16];
        assign in_dst  = dst_port_i >= lo && dst_port_i <= hi;
        assign in_src  = src_port_i >= lo && src_port_i <= hi;
        assign in_vid  = {4'h0, vid_sel} >= lo && {4'h0, vid_sel} <= hi;
        assign in_dscp = {10'h000, dscp_sel} >= lo && {10'h000, dscp_sel} <= hi;
        always_comb begin
            unique case (range_type_ff[g])
                tcar_pkg::RNG_DPORT: nxt_range_key[g] = in_dst;
                tcar_pkg::RNG_SPORT: nxt_range_key[g] = in_src;
                tcar_pkg::RNG_BOTH:  nxt_range_key[g] = in_dst | in_src;
                tcar_pkg::RNG_VID:   nxt_range_key[g] = in_vid;
                tcar_pkg::RNG_DSCP:  nxt_range_key[g] = in_dscp;
                default:             nxt_range_key[g] = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            range_key_valid_o <= 1'b0;
            range_key_o       <= 8'h00;
        end else begin
            // The third lookup only keys TCP/UDP frames; the second keys all.
            range_key_valid_o <= frame_valid_i & (~lookup_third_i | frame_tcp_udp_i);
            if (frame_valid_i) begin
                range_key_o <= (lookup_third_i && !frame_tcp_udp_i) ?
                               8'h00 : nxt_range_key;
            end
        end
    end

endmodule // tcar_top

// [tb/tcar_props.sv]
// Checker of action decode, range key and bus timing.
`timescale 1ns/1ps
module tcar_props (
    input wire logic clk_i, reset_n_i, psel_i, penable_i, pready_o, action_valid_i,
    input wire logic tcam_match_i, decode_valid_o, hit_set_o, encap_push_o,
    input wire logic oam_endpoint_apply_o, frame_valid_i, lookup_third_i, frame_tcp_udp_i,
    input wire logic range_key_valid_o,
    input wire logic [91:0] action_i, action_update_o,
    input wire logic [2:0] tag_b_priority_value_o, label_pop_count_o,
    input wire logic [7:0] range_key_o
);
    logic [91:0] act_q;
    always_ff @(posedge clk_i) act_q <= action_i;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    a_decode_pulse: assert property (action_valid_i |=> decode_valid_o)
        else $error("decode pulse missing");
    a_prio_copy: assert property (action_valid_i |=> tag_b_priority_value_o == act_q[47:45])
        else $error("priority mismatch");
    a_encap_zero: assert property (action_valid_i && action_i[58:49] == 10'h000 |=> !encap_push_o)
        else $error("push with zero index");
    a_pop_override: assert property (action_valid_i && action_i[64:62] != 3'h0
        |=> label_pop_count_o == act_q[64:62]) else $error("pop not overridden");
    a_oam_flag: assert property (action_valid_i |=> oam_endpoint_apply_o == act_q[75])
        else $error("oam flag mismatch");
    a_hit_mark: assert property (action_valid_i && tcam_match_i |=> hit_set_o && action_update_o[91])
        else $error("hit not marked");
    a_key_pulse: assert property (frame_valid_i && !(lookup_third_i && !frame_tcp_udp_i)
        |=> range_key_valid_o) else $error("key pulse missing");
    a_third_quiet: assert property (frame_valid_i && lookup_third_i && !frame_tcp_udp_i
        |=> !range_key_valid_o && range_key_o == 8'h00) else $error("key for non tcp");
    a_bus_wait: assert property (psel_i && !penable_i |=> !pready_o ##1 pready_o)
        else $error("bus wait wrong");
    c_hit: cover property (hit_set_o);
    c_key: cover property (range_key_valid_o && range_key_o != 8'h00);
    c_bus: cover property (pready_o);
endmodule // tcar_props
bind tcar_top tcar_props chk_u (.*);

// [tb/tcar_pipe_model.sv]
// Pipeline side model: per group path state and header pop count.
`timescale 1ns/1ps
module tcar_pipe_model (
    input  wire logic        clk_i,            // Clock.
    input  wire logic        reset_n_i,        // Reset, active low.
    output logic      [22:0] path_protected_o, // Group uses protected path.
    output logic      [2:0]  header_pop_o      // Header pop count.
);
    // Path states shift every cycle, as a live protection switch-over may do.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i)
            {path_protected_o, header_pop_o} <= 26'h2d2d2d5;
        else
            {path_protected_o, header_pop_o} <= {path_protected_o[21:0], header_pop_o,
                path_protected_o[22] ^ header_pop_o[1]};
    end
endmodule // tcar_pipe_model

// [tb/tb_tcar_top.sv]
// Bench comparing the block with a behavioural model.
`timescale 1ns/1ps
module tb_tcar_top;
    logic clk_i = 0, reset_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0, er, e, g, m;
    logic action_valid_i = 0, tcam_match_i = 0, frame_valid_i = 0, lookup_third_i = 0;
    logic frame_tcp_udp_i = 0, frame_tagged_i = 0, pready_o, pslverr_o, decode_valid_o;
    logic tag_b_drop_eligible_value_o, encap_push_o, egress_service_valid_o, hit_set_o;
    logic oam_endpoint_apply_o, protection_group_valid_o, protection_discard_o, range_key_valid_o;
    logic [2:0] header_label_pop_count_i, tag_b_priority_value_o, label_pop_count_o, h;
    logic [5:0] translated_dscp_i = 0, classified_dscp_i = 0, encap_push_bytes_o;
    logic [5:0] oam_endpoint_index_o;
    logic [6:0] protection_group_index_o;
    logic [7:0] range_key_o, k;
    logic [9:0] encapsulation_index_o, egress_service_index_o;
    logic [11:0] frame_vid_i = 0, port_vid_i = 0, classified_vid_i = 0;
    logic [12:0] paddr_i = 0;
    logic [15:0] src_port_i = 0, dst_port_i = 0;
    logic [22:0] path_protected_i, p;
    logic [31:0] pwdata_i = 0, prdata_o, rd;
    logic [91:0] action_i = 0, action_update_o, a;
    int failures = 0, samples_checked = 0, cyc = 0, v, s, typ[8], lo[8], hi[8];
    tcar_pipe_model pipe_u (.clk_i, .reset_n_i, .path_protected_o(path_protected_i),
        .header_pop_o(header_label_pop_count_i));
    tcar_top dut_u (.*);
    always #5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 2000) begin
            failures++;
            test_done();
        end
    end
    task automatic test_done();
        $display("failures %0d samples_checked %0d", failures, samples_checked);
        if (failures == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [91:0] got, exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("Error %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [12:0] ad, input logic [31:0] d);
        @(posedge clk_i);
        {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'b10, w, ad, d};
        @(posedge clk_i);
        penable_i <= 1'b1;
        do @(posedge clk_i); while (pready_o !== 1'b1);
        {rd, er} = {prdata_o, pslverr_o};
        {psel_i, penable_i} <= 2'b00;
    endtask
    function automatic logic [12:0] ba(int l, int o);
        return 13'(tcar_pkg::LOOKUP_STRIDE * (l + 1) + o);
    endfunction
    function automatic logic inr(int x, int i);
        return x >= lo[i] && x <= hi[i];
    endfunction
    initial begin
        void'($urandom(23));
        repeat (3) @(posedge clk_i);
        reset_n_i <= 1'b1;
        apb(0, tcar_pkg::REG_RANGE_TYPE, 0);
        chk(rd, 0);
        for (int i = 0; i < 8; i++) begin
            typ[i] = i % 5;
            lo[i] = $urandom_range(0, 40);
            hi[i] = lo[i] + $urandom_range(0, 20);
            apb(1, 13'(tcar_pkg::REG_RANGE_BOUND + 4 * i), 32'(hi[i] << 16 | lo[i]));
            a[3 * i +: 3] = 3'(typ[i]);
        end
        apb(1, tcar_pkg::REG_RANGE_TYPE, a[31:0]);
        apb(0, tcar_pkg::REG_RANGE_BOUND + 13'h01c, 0);
        chk(rd, 32'(hi[7] << 16 | lo[7]));
        for (int l = 0; l < 4; l++) apb(1, ba(l, tcar_pkg::OFS_ACTION), 32'(l * 7 + 1));
        for (int l = 0; l < 4; l++) begin
            apb(0, ba(l, tcar_pkg::OFS_ACTION), 0);
            chk(rd, l * 7 + 1);
            apb(0, ba(l, tcar_pkg::OFS_CONST + 4 * l), 0);
            chk(rd, tcar_pkg::LK_CONST[l][l]);
        end
        apb(0, 13'h1400, 0);
        chk({er, rd}, 33'h100000000);
        for (int n = 0; n < 60; n++) begin
            a = 92'({$urandom, $urandom, $urandom});
            if (n % 3 == 0) a[90:49] = {7'(n % 23), a[83:75], 10'(n), a[64:59], 10'h000};
            @(posedge clk_i);
            {action_valid_i, tcam_match_i, action_i} <= {1'b1, 1'(n % 2), a};
            @(posedge clk_i);
            action_valid_i <= 1'b0;
            {m, p, h} = {tcam_match_i, path_protected_i, header_label_pop_count_i};
            #1;
            e = a[58:49] != 0 && a[61:59] > 1;
            g = a[90:84] < 23;
            chk({decode_valid_o, tag_b_priority_value_o, tag_b_drop_eligible_value_o, encap_push_o,
                encapsulation_index_o, encap_push_bytes_o, label_pop_count_o, egress_service_valid_o,
                oam_endpoint_index_o, protection_group_valid_o, protection_discard_o, hit_set_o,
                action_update_o[91], egress_service_index_o, protection_group_index_o},
                {1'b1, a[47:45], a[48], e, a[58:49], e ? 6'(4 * a[61:59] + 6) : 6'h00,
                a[64:62] ? a[64:62] : h, a[74:65] < 256, a[75] ? a[81:76] : 6'h00, g,
                g && (a[83:82] == 1 ? p[a[90:84]] : a[83:82] == 2 && !p[a[90:84]]), m, a[91] | m,
                a[74:65], a[90:84]});
        end
        apb(0, ba(3, tcar_pkg::OFS_STICKY), 0);
        chk(rd[0], 1);
        repeat (60) begin
            @(posedge clk_i);
            frame_valid_i <= 1'b1;
            {lookup_third_i, frame_tcp_udp_i, frame_tagged_i} <= 3'($urandom);
            {src_port_i, dst_port_i} <= $urandom & 32'h003f003f;
            {frame_vid_i, port_vid_i} <= 24'($urandom & 32'h03f03f);
            {classified_vid_i, translated_dscp_i, classified_dscp_i} <= 24'($urandom & 32'h03ffff);
            @(posedge clk_i);
            frame_valid_i <= 1'b0;
            v = lookup_third_i ? classified_vid_i : frame_tagged_i ? frame_vid_i : port_vid_i;
            s = lookup_third_i ? classified_dscp_i : translated_dscp_i;
            for (int i = 0; i < 8; i++)
                k[i] = (typ[i] inside {0, 2} && inr(dst_port_i, i)) || (typ[i] == 3 && inr(v, i))
                    || (typ[i] inside {1, 2} && inr(src_port_i, i)) || (typ[i] == 4 && inr(s, i));
            #1;
            chk({range_key_valid_o, range_key_o}, lookup_third_i && !frame_tcp_udp_i ? 9'h000 : {1'b1, k});
        end
        test_done();
    end
endmodule // tb_tcar_top
